// [design/partial_bitstream_delivery.sv]
// Configuration engine front end taking partial, blanking and clearing bitstreams.
// Assumes an AHB-Lite master on hclk and an internal word port synchronous to hclk.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module partial_bitstream_delivery
    import pr_loader_pkg::*;
#(
    parameter int          TIE_W     = TIE_W_DEF,
    parameter logic [31:0] SYNC_WORD = SYNC_WORD_DEF,
    parameter logic [31:0] CHECK_CMD = CHECK_CMD_DEF
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              internal_config_port_valid,
    input  wire logic [31:0]       internal_config_port_data,
    output logic                   internal_config_port_ready,
    output logic                   done_pin,
    output logic                   user_mode,
    output logic                   region_clk_en,
    output logic                   region_init,
    output logic                   region_blanked,
    output logic      [TIE_W-1:0]  region_tie_level,
    output logic                   irq
);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------------
    logic [7:0]        addr_q;
    logic              wr_q;
    logic [31:0]       ctrl;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [TIE_W-1:0]  tie_high;
    logic [WORDS_W-1:0] word_count;
    load_state_t       state;
    logic [1:0]        kind;
    logic [31:0]       crc_acc;
    logic              crc_bad;
    logic              mask_armed;
    logic              initialized;
    cfg_word_t         in_word;
    logic              start_evt;
    logic              end_evt;
    logic              load_ok;
    logic [IRQ_W-1:0]  events;
    logic              accept;

    assign accept = hsel && hready && htrans[1];

    function automatic logic [31:0] read_reg(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFF_CTRL:       v = ctrl;
            OFF_STATUS: begin
                v[STAT_BUSY]       = (state != ST_IDLE);
                v[STAT_DONE]       = done_pin;
                v[STAT_CLK_EN]     = region_clk_en;
                v[STAT_MASK_ARMED] = mask_armed;
                v[STAT_INIT]       = initialized;
                v[STAT_BLANKED]    = region_blanked;
            end
            OFF_IRQ_STATUS: v[IRQ_W-1:0] = irq_status;
            OFF_IRQ_MASK:   v[IRQ_W-1:0] = irq_mask;
            OFF_TIE_HIGH:   v[TIE_W-1:0] = tie_high;
            OFF_WORDS:      v[WORDS_W-1:0] = word_count;
            default:        v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_reg

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q    <= 8'h00;
            wr_q      <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_q      <= accept && hwrite;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
            // Read data is latched in the address phase so it stands in the data phase
            if (accept && !hwrite) begin
                hrdata <= read_reg(haddr[7:0]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Control, mask and tie-high registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl     <= CTRL_RESET;
            irq_mask <= '0;
            tie_high <= '0;
        end else if (wr_q) begin
            case (addr_q)
                OFF_CTRL:     ctrl     <= hwdata & CTRL_WMASK;
                OFF_IRQ_MASK: irq_mask <= hwdata[IRQ_W-1:0];
                OFF_TIE_HIGH: tie_high <= hwdata[TIE_W-1:0];
                default:      ctrl     <= ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Port selection
    // ------------------------------------------------------------------
    // A word in flight while select flips is lost; software must switch only when idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            internal_config_port_ready <= 1'b0;
        end else begin
            internal_config_port_ready <= !ctrl[CTRL_PORT_SEL];
        end
    end

    always_comb begin
        in_word.valid = 1'b0;
        in_word.data  = 32'h0000_0000;
        if (!ctrl[CTRL_PORT_SEL]) begin
            in_word.valid = internal_config_port_valid && internal_config_port_ready;
            in_word.data  = internal_config_port_data;
        end else if (wr_q && (addr_q == OFF_DATA)) begin
            in_word.valid = 1'b1;
            in_word.data  = hwdata;
        end
    end

    // ------------------------------------------------------------------
    // Stream parser
    // ------------------------------------------------------------------
    // Frame addresses travel inside the stream, so no region address is held
    assign start_evt = (state == ST_IDLE) && in_word.valid && (in_word.data == SYNC_WORD);
    assign end_evt   = (state == ST_BODY) && in_word.valid && (in_word.data == DESYNC_WORD);
    assign load_ok   = end_evt && !crc_bad;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= ST_IDLE;
            kind    <= KIND_PARTIAL;
            crc_acc <= 32'h0000_0000;
            crc_bad <= 1'b0;
        end else if (in_word.valid) begin
            case (state)
                ST_IDLE: begin
                    if (start_evt) begin
                        state   <= ST_KIND;
                        crc_acc <= 32'h0000_0000;
                        crc_bad <= 1'b0;
                    end
                end
                ST_KIND: begin
                    kind  <= in_word.data[1:0];
                    state <= ST_BODY;
                end
                ST_BODY: begin
                    if (end_evt) begin
                        state <= ST_IDLE;
                    end else if (in_word.data == CHECK_CMD) begin
                        state <= ST_CHECK;
                    end else begin
                        crc_acc <= crc_acc ^ in_word.data;
                    end
                end
                ST_CHECK: begin
                    // Per-frame check: the checksum restarts after each compare
                    if (in_word.data != crc_acc) begin
                        crc_bad <= 1'b1;
                    end
                    crc_acc <= 32'h0000_0000;
                    state   <= ST_BODY;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_count <= '0;
        end else if (start_evt) begin
            word_count <= '0;
        end else if (in_word.valid && (state != ST_IDLE)) begin
            word_count <= word_count + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Done pin and user mode
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_pin  <= 1'b1;
            user_mode <= 1'b0;
        end else begin
            user_mode <= 1'b1;
            if (start_evt && ctrl[CTRL_RST_AFTER]) begin
                done_pin <= 1'b0;
            end else if (load_ok && ctrl[CTRL_RST_AFTER] && (kind != KIND_CLEAR)) begin
                done_pin <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Region control
    // ------------------------------------------------------------------
    // Region signals and the done pin change at the end of a load; no startup runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            region_clk_en    <= 1'b1;
            region_init      <= 1'b0;
            region_blanked   <= 1'b0;
            region_tie_level <= '0;
            mask_armed       <= 1'b0;
            initialized      <= 1'b1;
        end else begin
            region_init <= 1'b0;
            if (load_ok) begin
                if (kind == KIND_CLEAR) begin
                    region_clk_en <= 1'b0;
                    mask_armed    <= 1'b1;
                end else begin
                    region_clk_en    <= 1'b1;
                    mask_armed       <= 1'b0;
                    region_blanked   <= (kind == KIND_BLANK);
                    region_tie_level <= (kind == KIND_BLANK) ? tie_high : '0;
                    if (ctrl[CTRL_CLEAR_FAM] && !mask_armed) begin
                        initialized <= 1'b0;
                    end else begin
                        initialized <= 1'b1;
                        region_init <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts: sticky, write one to clear, set wins over clear
    // ------------------------------------------------------------------
    always_comb begin
        events             = '0;
        events[IRQ_LOAD]   = load_ok && (kind != KIND_CLEAR);
        events[IRQ_CLEAR]  = load_ok && (kind == KIND_CLEAR);
        events[IRQ_CRC]    = end_evt && crc_bad;
        events[IRQ_UNINIT] = load_ok && (kind != KIND_CLEAR) && ctrl[CTRL_CLEAR_FAM] && !mask_armed;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_q && (addr_q == OFF_IRQ_STATUS)) begin
                irq_status <= (irq_status & ~hwdata[IRQ_W-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_done_drop_start: assert property (start_evt && ctrl[CTRL_RST_AFTER] |=> !done_pin)
        else $error("done pin did not drop at bitstream start");
    a_done_rise_ok: assert property (load_ok && ctrl[CTRL_RST_AFTER] && kind != KIND_CLEAR |=> done_pin)
        else $error("done pin did not rise after a good load");
    a_done_clear_low: assert property (start_evt && ctrl[CTRL_RST_AFTER] ##1
        (!end_evt || kind == KIND_CLEAR) [*2] |=> !done_pin)
        else $error("done pin rose during a clearing sequence");
    a_clear_stops_clk: assert property (load_ok && kind == KIND_CLEAR |=> !region_clk_en && mask_armed
        && !region_init)
        else $error("clearing bitstream did not stop region clocks");
    a_uninit_module: assert property (load_ok && kind != KIND_CLEAR && ctrl[CTRL_CLEAR_FAM] && !mask_armed
        |=> !initialized && !region_init)
        else $error("module initialized without a prior clear");
    a_init_after_load: assert property (load_ok && kind != KIND_CLEAR && (!ctrl[CTRL_CLEAR_FAM] || mask_armed)
        |=> region_init && initialized ##1 !region_init)
        else $error("region init pulse missing or too long");
    a_crc_blocks: assert property (end_evt && crc_bad |=> $stable(region_clk_en) && !region_init)
        else $error("bad checksum still changed the region");
    a_blank_tie: assert property (load_ok && kind == KIND_BLANK |=> region_blanked
        && region_tie_level == $past(tie_high))
        else $error("blanking tie levels wrong");
    a_port_gate: assert property ($past(ctrl[CTRL_PORT_SEL]) |-> !internal_config_port_ready)
        else $error("internal port ready while processor port selected");
    a_user_mode: assert property ($past(hresetn) |-> user_mode)
        else $error("device left user mode");
    a_irq_level: assert property (|(irq_status & irq_mask) |=> irq)
        else $error("unmasked interrupt not signalled");

    c_clear_then_partial: cover property (load_ok && kind == KIND_CLEAR ##[1:200] load_ok && kind != KIND_CLEAR);
    c_blank_load:         cover property (load_ok && kind == KIND_BLANK);
    c_crc_error:          cover property (end_evt && crc_bad);
    c_internal_port:      cover property (start_evt && !ctrl[CTRL_PORT_SEL]);

endmodule : partial_bitstream_delivery

`default_nettype wire

// [design/pr_loader_pkg.sv]
// Constants, types and register map of the partial bitstream loader.
// Assumes a single 200 MHz clock domain and an AHB-Lite register bus.
package pr_loader_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one word per register)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STATUS     = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;
    localparam logic [7:0]  OFF_TIE_HIGH   = 8'h10;
    localparam logic [7:0]  OFF_DATA       = 8'h14;
    localparam logic [7:0]  OFF_WORDS      = 8'h18;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int          CTRL_RST_AFTER  = 0;
    localparam int          CTRL_CLEAR_FAM  = 1;
    localparam int          CTRL_PORT_SEL   = 27;
    localparam int          CTRL_PORT_MODE  = 28;
    localparam logic [31:0] CTRL_RESET      = 32'h1800_0000;
    localparam logic [31:0] CTRL_WMASK      = 32'h1800_0003;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int          STAT_BUSY       = 0;
    localparam int          STAT_DONE       = 1;
    localparam int          STAT_CLK_EN     = 2;
    localparam int          STAT_MASK_ARMED = 3;
    localparam int          STAT_INIT       = 4;
    localparam int          STAT_BLANKED    = 5;

    // ------------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------------
    localparam int          IRQ_W           = 4;
    localparam int          IRQ_LOAD        = 0;
    localparam int          IRQ_CLEAR       = 1;
    localparam int          IRQ_CRC         = 2;
    localparam int          IRQ_UNINIT      = 3;

    // ------------------------------------------------------------------
    // Stream command words and bitstream kinds
    // ------------------------------------------------------------------
    localparam logic [31:0] SYNC_WORD_DEF   = 32'h5A5A_0001;
    localparam logic [31:0] CHECK_CMD_DEF   = 32'h5A5A_0002;
    localparam logic [31:0] DESYNC_WORD     = 32'h0000_000D;
    localparam logic [1:0]  KIND_PARTIAL    = 2'h0;
    localparam logic [1:0]  KIND_BLANK      = 2'h1;
    localparam logic [1:0]  KIND_CLEAR      = 2'h2;
    localparam int          TIE_W_DEF       = 8;
    localparam int          WORDS_W         = 16;

    typedef enum logic [1:0] {ST_IDLE, ST_KIND, ST_BODY, ST_CHECK} load_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } cfg_word_t;

endpackage : pr_loader_pkg

// [testbench/tb.sv]
// Self-checking bench for the partial bitstream loader.
// Assumes the loader answers AHB-Lite with no wait states and the word source model.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pr_loader_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, internal_config_port_data;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        internal_config_port_valid, internal_config_port_ready, done_pin, user_mode;
    logic        region_clk_en, region_init, region_blanked, irq;
    logic [7:0]  tie;
    int          fail_count, checks_done, init_seen;

    always #2.5 hclk = ~hclk;

    // Init pulse lasts one cycle, so it is counted away from the edge that launches it
    always @(negedge hclk) if (region_init === 1'b1) init_seen++;

    partial_bitstream_delivery DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .internal_config_port_valid(internal_config_port_valid),
        .internal_config_port_data(internal_config_port_data),
        .internal_config_port_ready(internal_config_port_ready), .done_pin(done_pin), .user_mode(user_mode),
        .region_clk_en(region_clk_en), .region_init(region_init), .region_blanked(region_blanked),
        .region_tie_level(tie), .irq(irq));
    word_port_source u_src (.clk(hclk), .ready(internal_config_port_ready), .valid(internal_config_port_valid),
        .data(internal_config_port_data));

    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : check

    // ------------------------------------------------------------------
    // Single-word AHB-Lite transfer, address phase then data phase
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 50);
            if (hreadyout !== 1'b1) begin
                fail_count++;
                wrap_up();
            end
            if (ph == 0) begin
                htrans <= 2'h0;
                hsel   <= 1'b0;
                hwdata <= wd;
            end
        end
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        check(name, r & m, e);
        check("hresp", 32'(hresp), 32'h0);
    endtask : rd_chk

    // Whole stream: sync, kind, two body words, checksum pair, desync word
    task automatic load(input logic [1:0] kind, input logic [31:0] b0, input logic [31:0] b1,
                        input logic internal, input logic bad);
        logic [31:0] w [7];
        logic        ok;
        w = '{SYNC_WORD_DEF, {30'h0, kind}, b0, b1, CHECK_CMD_DEF, b0 ^ b1 ^ {31'h0, bad}, DESYNC_WORD};
        init_seen = 0;
        for (int i = 0; i < 7; i++) begin
            if (internal) begin
                u_src.send(w[i], i % 3, ok);
                if (!ok) begin
                    fail_count++;
                    wrap_up();
                end
            end else wr(OFF_DATA, w[i]);
            if (i == 3) check("done_mid", 32'(done_pin), 32'h0);
        end
        // Wait four cycles until the completion effects have settled
        repeat (4) @(posedge hclk);
    endtask : load

    task automatic sc_reset();
        check("done_rst", 32'(done_pin), 32'h1);
        check("clk_en_rst", 32'(region_clk_en), 32'h1);
        check("ready_rst", 32'(hreadyout), 32'h0);
    endtask : sc_reset

    task automatic sc_partial_data_port();
        check("user_mode", 32'(user_mode), 32'h1);
        rd_chk("ctrl_rst", OFF_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
        wr(OFF_CTRL, 32'h1800_0001);
        wr(OFF_IRQ_MASK, 32'h0000_000F);
        load(KIND_PARTIAL, 32'h1234_5678, 32'hA5A5_0F0F, 1'b0, 1'b0);
        check("done_end", 32'(done_pin), 32'h1);
        check("user_mode_end", 32'(user_mode), 32'h1);
        check("blanked", 32'(region_blanked), 32'h0);
        check("init_pulse", 32'(init_seen), 32'h1);
        check("irq_up", 32'(irq), 32'h1);
        rd_chk("init", OFF_STATUS, 32'h0000_0010, 32'h0000_0010);
        rd_chk("words", OFF_WORDS, 32'h0000_FFFF, 32'h0000_0006);
        rd_chk("irq_load", OFF_IRQ_STATUS, 32'h0000_000F, 32'h0000_0001);
        wr(OFF_IRQ_STATUS, 32'h0000_000F);
        repeat (2) @(posedge hclk);
        check("irq_clr", 32'(irq), 32'h0);
        rd_chk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask : sc_partial_data_port

    task automatic sc_clear_then_blank();
        wr(OFF_CTRL, 32'h1000_0003);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        wr(OFF_TIE_HIGH, 32'h0000_005A);
        repeat (2) @(posedge hclk);
        check("int_port", 32'(internal_config_port_ready), 32'h1);
        load(KIND_CLEAR, 32'h0F0F_0001, 32'h0F0F_0002, 1'b1, 1'b0);
        check("done_clear", 32'(done_pin), 32'h0);
        check("clk_stop", 32'(region_clk_en), 32'h0);
        check("init_clear", 32'(init_seen), 32'h0);
        check("irq_masked", 32'(irq), 32'h0);
        rd_chk("mask_armed", OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
        rd_chk("irq_clear", OFF_IRQ_STATUS, 32'h0000_000F, 32'h0000_0002);
        load(KIND_BLANK, 32'h7777_0000, 32'h0000_7777, 1'b1, 1'b0);
        check("done_blank", 32'(done_pin), 32'h1);
        check("blanked_on", 32'(region_blanked), 32'h1);
        check("init_blank", 32'(init_seen), 32'h1);
        check("tie", 32'(tie), 32'h0000_005A);
        rd_chk("irq_blank", OFF_IRQ_STATUS, 32'h0000_000F, 32'h0000_0003);
    endtask : sc_clear_then_blank

    task automatic sc_uninit_and_bad_sum();
        wr(OFF_IRQ_STATUS, 32'h0000_000F);
        load(KIND_PARTIAL, 32'h0000_FFFF, 32'hFFFF_0000, 1'b1, 1'b0);
        rd_chk("uninit", OFF_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
        check("tie_off", 32'(tie), 32'h0000_0000);
        check("init_none", 32'(init_seen), 32'h0);
        wr(OFF_IRQ_STATUS, 32'h0000_000F);
        load(KIND_BLANK, 32'h1111_2222, 32'h3333_4444, 1'b1, 1'b1);
        check("done_bad", 32'(done_pin), 32'h0);
        check("blanked_kept", 32'(region_blanked), 32'h0);
        check("init_bad", 32'(init_seen), 32'h0);
        rd_chk("irq_crc", OFF_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004);
        wr(OFF_CTRL, 32'h1800_0001);
        repeat (2) @(posedge hclk);
        check("port_back", 32'(internal_config_port_ready), 32'h0);
    endtask : sc_uninit_and_bad_sum

    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end

    initial begin
        fail_count  = 0;
        checks_done = 0;
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0000_0000;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0000_0000;
        repeat (20) @(posedge hclk);
        sc_reset();
        hresetn <= 1'b1;
        // User mode is launched by the first edge after release, so look one edge later
        repeat (2) @(posedge hclk);
        sc_partial_data_port();
        sc_clear_then_blank();
        sc_uninit_and_bad_sum();
        wrap_up();
    end
endmodule : tb
`default_nettype wire

// [testbench/word_port_source.sv]
// Behavioural reconfiguration controller driving the loader's internal word port.
// Assumes the loader takes a word at a rising edge where valid and ready are high.
`timescale 1ns/10ps
`default_nettype none
module word_port_source (
    input  wire logic        clk,
    input  wire logic        ready,
    output logic             valid,
    output logic      [31:0] data
);
    initial begin
        valid = 1'b0;
        data  = 32'h0000_0000;
    end

    // Word held until ready is sampled; afterwards the data lines show the inverse
    // so a stale word is never mistaken for a fresh one
    task automatic send(input logic [31:0] w, input int stall, output logic ok);
        int n;
        repeat (stall + 1) @(posedge clk);
        valid <= 1'b1;
        data  <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 100);
        ok = (ready === 1'b1);
        valid <= 1'b0;
        data  <= ~w;
    endtask : send
endmodule : word_port_source
`default_nettype wire
